/* dsw_sleep_ctrl.sv */
// Sleep-entry and wake-up sequencer of the signal-processor core.
// Assumes the power manager answers standby and wake handshakes asynchronously to clk_sys.
`timescale 1ns/100ps
`include "dsw_map.svh"
// Overview of operation
// - Sleep needs idle instruction plus command bit 16
// - Standby handshake succeeds only with emulation clock
// - Emulation clock free-runs with debugger or forced-wakeup
// - External events 95:32 wake the sleeping core
// - Internal events 31:16 do not wake core
// - DMA completions feed internal events and exported
module dsw_sleep_ctrl #(
   parameter int WATCH_CYCLES = `DSW_EMU_WATCH_CYCLES
) (
   input  wire logic                          clk_sys,
   input  wire logic                          rst_n,
   input  wire logic                          idle_exec,
   input  wire logic [`DSW_CMD_WIDTH-1:0]     power_down_command_reg,
   input  wire logic [`DSW_CTC_WIDTH-1:0]     clock_transition_control,
   input  wire logic                          debugger_attached,
   input  wire logic                          emu_clk_src,
   input  wire logic [`DSW_EVT_WIDTH-1:0]     evt_in,
   input  wire dsw_pkg::dsw_dma_irq_t         dma_irq,
   input  wire logic                          pm_idle_ack,
   input  wire logic                          pm_wake_ack,
   output logic                               emu_clk_core,
   output logic                               master_standby_request,
   output logic                               core_halted,
   output logic                               core_resume,
   output dsw_pkg::dsw_dma_irq_t              dma_irq_out,
   output logic [`DSW_DMA_REGIONS:0]          internal_dma_evt,
   output dsw_pkg::dsw_state_t                state
);
   import dsw_pkg::*;

   // Externally routed event range, the only one that can wake the core
   localparam int EXT_WIDTH = `DSW_EXT_EVT_HI - `DSW_EXT_EVT_LO + 1;

   // Refuse settings that the counters and decodes cannot serve
   if (WATCH_CYCLES < 2 || WATCH_CYCLES >= (1 << `DSW_EMU_CNT_WIDTH))
   begin : g_bad_watch
      $error("dsw_sleep_ctrl: WATCH_CYCLES out of range");
   end
   if (`DSW_EXT_EVT_HI >= `DSW_EVT_WIDTH || `DSW_EXT_EVT_LO <= `DSW_INT_EVT_HI)
   begin : g_bad_evt_map
      $error("dsw_sleep_ctrl: event ranges do not fit the event bus");
   end
   if (`DSW_PDC_SLEEP_BIT >= `DSW_CMD_WIDTH)
   begin : g_bad_cmd_bit
      $error("dsw_sleep_ctrl: sleep command bit outside the command word");
   end

   // Standby is held from handshake start until a wake event
   function automatic logic in_low_power(input dsw_state_t s);
      in_low_power = (s == DSW_STANDBY) || (s == DSW_SLEEP);
   endfunction

   // The core is parked in every state but RUN
   function automatic logic is_parked(input dsw_state_t s);
      is_parked = (s != DSW_RUN);
   endfunction

   // Synchroniser stages and the state being entered
   dsw_state_t           next_state;
   logic [1:0]           idle_sync;
   logic [1:0]           dbg_sync;
   logic [1:0]           ack_sync;
   logic [1:0]           wack_sync;
   logic [EXT_WIDTH-1:0] evt_s1;
   logic [EXT_WIDTH-1:0] evt_s2;
   logic                 emu_active;

   // Emulation clock gating: free-running in either enabling condition
   wire forced_wakeup_mode = (clock_transition_control == `DSW_CTC_FORCED_WAKEUP);
   wire emu_run            = dbg_sync[1] || forced_wakeup_mode;
   assign emu_clk_core     = emu_clk_src & emu_run;

   // Entry request needs both the idle instruction and the command bit
   wire sleep_req  = idle_sync[1] && power_down_command_reg[`DSW_PDC_SLEEP_BIT];
   // Only the externally routed range is brought in and can wake the core;
   // subsystem-internal events never reach the wake decision
   wire ext_wake   = |evt_s2;
   wire wake_req   = ext_wake;

   // Registered outputs follow the state being entered
   wire next_standby = in_low_power(next_state);
   wire next_halted  = is_parked(next_state);
   wire next_resume  = (state == DSW_WAKE) && (next_state == DSW_RUN);

   dsw_emu_watch #(
      .WATCH_CYCLES (WATCH_CYCLES)
   ) u_emu_watch (
      .clk_sys    (clk_sys),
      .rst_n      (rst_n),
      .emu_clk    (emu_clk_core),
      .emu_active (emu_active)
   );

   always_comb
   begin
      next_state = state;
      unique case (state)
         DSW_RUN:
            if (sleep_req)
               next_state = DSW_ARMED;
         DSW_ARMED:
            if (!sleep_req)
               next_state = DSW_RUN;
            else if (emu_active)
               next_state = DSW_STANDBY;
         DSW_STANDBY:
            if (wake_req)
               next_state = DSW_WAKE;
            else if (ack_sync[1] && emu_active)
               next_state = DSW_SLEEP;
         DSW_SLEEP:
            if (wake_req)
               next_state = DSW_WAKE;
         DSW_WAKE:
            if (wack_sync[1])
               next_state = DSW_RUN;
         default:
            next_state = DSW_RUN;
      endcase
   end

   // Two-stage synchronisers for the idle, debugger, acknowledge and external event inputs
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         idle_sync <= 2'h0;
      else
         idle_sync <= {idle_sync[0], idle_exec};
   end

   // Debugger presence gates the emulation clock
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         dbg_sync <= 2'h0;
      else
         dbg_sync <= {dbg_sync[0], debugger_attached};
   end

   // Power manager acknowledges arrive as levels from another domain
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         ack_sync <= 2'h0;
      else
         ack_sync <= {ack_sync[0], pm_idle_ack};
   end

   // Wake acknowledge, same treatment
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         wack_sync <= 2'h0;
      else
         wack_sync <= {wack_sync[0], pm_wake_ack};
   end

   // Event levels: only the externally routed range is synchronised
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         evt_s1 <= '0;
         evt_s2 <= '0;
      end
      else
      begin
         evt_s1 <= evt_in[`DSW_EXT_EVT_HI:`DSW_EXT_EVT_LO];
         evt_s2 <= evt_s1;
      end
   end

   // State register
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         state <= DSW_RUN;
      else
         state <= next_state;
   end

   // Handshake outputs are registered together with the state they belong to
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         master_standby_request <= 1'b0;
         core_halted            <= 1'b0;
         core_resume            <= 1'b0;
      end
      else
      begin
         master_standby_request <= next_standby;
         core_halted            <= next_halted;
         core_resume            <= next_resume;
      end
   end

   // Completion interrupts feed the internal events and the crossbar export
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dma_irq_out      <= '0;
         internal_dma_evt <= '0;
      end
      else
      begin
         dma_irq_out      <= dma_irq;
         internal_dma_evt <= {dma_irq.region, dma_irq.global_irq};
      end
   end
endmodule // dsw_sleep_ctrl

/* dsw_map.svh */
// Constants for the signal-processor sleep/wake controller.
// Included by the package and the design modules; definitions only.
`ifndef DSW_MAP_SVH
`define DSW_MAP_SVH
`define DSW_PDC_SLEEP_BIT     16
`define DSW_CMD_WIDTH         32
`define DSW_EVT_WIDTH         96
`define DSW_EXT_EVT_LO        32
`define DSW_EXT_EVT_HI        95
`define DSW_INT_EVT_LO        16
`define DSW_INT_EVT_HI        31
`define DSW_DMA_REGIONS       8
`define DSW_CTC_WIDTH         2
`define DSW_CTC_FORCED_WAKEUP 2'h2
`define DSW_EMU_WATCH_CYCLES  8
`define DSW_EMU_CNT_WIDTH     4
`endif

/* dsw_pkg.sv */
// Types for the signal-processor sleep/wake controller.
// Assumes dsw_map.svh is on the include path.
`include "dsw_map.svh"
package dsw_pkg;
   typedef struct packed {
      logic standby_req;
      logic idle_ack;
      logic wake_ack;
   } dsw_pm_t;
   typedef struct packed {
      logic [`DSW_DMA_REGIONS-1:0] region;
      logic                        global_irq;
   } dsw_dma_irq_t;
   typedef enum logic [4:0] {
      DSW_RUN      = 5'h01,
      DSW_ARMED    = 5'h02,
      DSW_STANDBY  = 5'h04,
      DSW_SLEEP    = 5'h08,
      DSW_WAKE     = 5'h10
   } dsw_state_t;
endpackage

/* dsw_emu_watch.sv */
// Emulation clock activity detector.
// Assumes emu_clk is asynchronous to clk_sys and slower than half its rate.
`timescale 1ns/100ps
`include "dsw_map.svh"
module dsw_emu_watch #(
   parameter int WATCH_CYCLES = `DSW_EMU_WATCH_CYCLES
) (
   input  wire logic clk_sys,
   input  wire logic rst_n,
   input  wire logic emu_clk,
   output logic      emu_active
);
   logic [2:0]                    sync;
   logic [`DSW_EMU_CNT_WIDTH-1:0] idle_cnt;
   wire                           edge_seen = sync[1] ^ sync[2];
   wire  [`DSW_EMU_CNT_WIDTH-1:0] watch_lim = `DSW_EMU_CNT_WIDTH'(WATCH_CYCLES);

   if (WATCH_CYCLES < 2 || WATCH_CYCLES >= (1 << `DSW_EMU_CNT_WIDTH))
   begin : g_bad_watch
      $error("dsw_emu_watch: WATCH_CYCLES out of range");
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         // Start saturated so that reset does not fake clock activity
         sync       <= 3'h0;
         idle_cnt   <= `DSW_EMU_CNT_WIDTH'(WATCH_CYCLES);
         emu_active <= 1'b0;
      end
      else
      begin
         sync <= {sync[1:0], emu_clk};
         if (edge_seen)
            idle_cnt <= '0;
         else if (idle_cnt != watch_lim)
            idle_cnt <= idle_cnt + 1'b1;
         emu_active <= edge_seen || (idle_cnt != watch_lim);
      end
   end
endmodule // dsw_emu_watch

/* dsw_sleep_checker.sv */
// Port assertions for the sleep/wake sequencer.
// Sees only dsw_sleep_ctrl ports; bound after the module.
`timescale 1ns/100ps
module dsw_sleep_checker (
   input wire logic                  clk_sys,
   input wire logic                  rst_n,
   input wire logic [31:0]           power_down_command_reg,
   input wire logic [1:0]            clock_transition_control,
   input wire logic                  emu_clk_src,
   input wire logic                  emu_clk_core,
   input wire logic [95:0]           evt_in,
   input wire dsw_pkg::dsw_dma_irq_t dma_irq,
   input wire logic                  master_standby_request,
   input wire logic                  core_halted,
   input wire logic                  core_resume,
   input wire dsw_pkg::dsw_dma_irq_t dma_irq_out,
   input wire logic [8:0]            internal_dma_evt,
   input wire dsw_pkg::dsw_state_t   state
);
   import dsw_pkg::*;
   logic       prev_emu;
   logic [4:0] quiet;
   always_ff @(posedge clk_sys) prev_emu <= emu_clk_core;
   // Cycles since the gated emulation clock last moved
   always_ff @(posedge clk_sys or negedge rst_n)
      if (!rst_n) quiet <= 5'h00;
      else if (emu_clk_core != prev_emu) quiet <= 5'h00;
      else if (quiet != 5'h1f) quiet <= quiet + 5'h01;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   a_emu_forced: assert property (emu_clk_src && clock_transition_control == 2'h2
      |-> emu_clk_core) else $error("gated emulation clock");
   a_sleep_cause: assert property ($rose(state == DSW_ARMED)
      |-> $past(power_down_command_reg[16])) else $error("armed without command");
   a_emu_needed: assert property (quiet > 5'h0e
      |-> !$rose(master_standby_request)) else $error("standby without emulation clock");
   a_standby_lvl: assert property (master_standby_request ==
      (state == DSW_STANDBY || state == DSW_SLEEP)) else $error("standby level");
   a_halt_lvl: assert property (core_halted == (state != DSW_RUN))
      else $error("halted level");
   a_resume_pulse: assert property (core_resume |-> state == DSW_RUN
      && $past(state) == DSW_WAKE ##1 !core_resume) else $error("resume pulse");
   a_ext_wake: assert property (state == DSW_SLEEP && evt_in[95:32] != '0
      |-> ##[1:4] state == DSW_WAKE) else $error("no wake on external event");
   a_int_ignored: assert property ((state == DSW_SLEEP && evt_in[95:32] == '0) [*4]
      |=> state == DSW_SLEEP) else $error("woke without external event");
   a_dma_export: assert property (dma_irq_out == $past(dma_irq)
      && internal_dma_evt == $past(dma_irq)) else $error("dma completion path");
   c_sleep: cover property (state == DSW_SLEEP);
   c_resume: cover property (core_resume);
   c_stalled: cover property (quiet > 5'h0e && state == DSW_ARMED);
endmodule // dsw_sleep_checker
bind dsw_sleep_ctrl dsw_sleep_checker i_chk (.clk_sys, .rst_n, .power_down_command_reg,
   .clock_transition_control, .emu_clk_src, .emu_clk_core, .evt_in, .dma_irq,
   .master_standby_request, .core_halted, .core_resume, .dma_irq_out,
   .internal_dma_evt, .state);

/* dsw_pm_model.sv */
// Behavioural power manager for the standby and wake handshakes.
// Answers after one cycle, or four when slow is high.
`timescale 1ns/100ps
module dsw_pm_model (
   input  wire logic clk_sys,
   input  wire logic rst_n,
   input  wire logic slow,
   input  wire logic standby_req,
   input  wire logic halted,
   output logic      idle_ack,
   output logic      wake_ack
);
   logic [7:0] pipe;
   always_ff @(posedge clk_sys or negedge rst_n)
      if (!rst_n) pipe <= 8'h00;
      else pipe <= {pipe[6:4], standby_req, pipe[2:0], halted & !standby_req};
   assign idle_ack = slow ? pipe[7] : pipe[4];
   assign wake_ack = slow ? pipe[3] : pipe[0];
endmodule // dsw_pm_model

/* tb_dsw_sleep_wake_control.sv */
// Self-checking bench of the sleep/wake sequencer.
// Assumes dsw_pkg, the design and dsw_pm_model are compiled first.
`timescale 1ns/100ps
module tb_dsw_sleep_wake_control;
   import dsw_pkg::*;
   logic         clk_sys, rst_n, idle_exec, dbg, emu_clk_src, slow, idle_ack, wake_ack;
   logic         emu_clk_core, standby, halted, resume;
   logic [31:0]  cmd;
   logic [1:0]   ctc;
   logic [95:0]  evt_in;
   logic [8:0]   int_evt;
   dsw_dma_irq_t dma_irq, dma_out;
   dsw_state_t   state;
   int           fail_count = 0, total_checks = 0;
   dsw_sleep_ctrl i_dut (.clk_sys, .rst_n, .idle_exec, .power_down_command_reg(cmd),
      .clock_transition_control(ctc), .debugger_attached(dbg), .emu_clk_src, .evt_in,
      .dma_irq, .pm_idle_ack(idle_ack), .pm_wake_ack(wake_ack), .emu_clk_core,
      .master_standby_request(standby), .core_halted(halted), .core_resume(resume),
      .dma_irq_out(dma_out), .internal_dma_evt(int_evt), .state);
   dsw_pm_model i_pm (.clk_sys, .rst_n, .slow, .standby_req(standby), .halted, .idle_ack,
      .wake_ack);
   task automatic chk(input string what, input logic [31:0] exp, got);
      total_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wait_st(input dsw_state_t s);
      for (int i = 0; i < 80 && state !== s; i++) @(negedge clk_sys);
   endtask
   task automatic t_no_idle();
      cmd = 32'h0001_0000;
      repeat (20) @(negedge clk_sys);
      chk("state", DSW_RUN, state);
      cmd = 32'h0;
   endtask
   task automatic t_sleep_wake();
      ctc = 2'h2;
      idle_exec = 1'b1;
      cmd = 32'h0001_0000;
      wait_st(DSW_SLEEP);
      chk("standby", 1, standby);
      evt_in[95] = 1'b1;
      wait_st(DSW_WAKE);
      chk("state", DSW_WAKE, state);
      {idle_exec, cmd, evt_in} = '0;
      for (int i = 0; i < 20 && resume !== 1'b1; i++) @(negedge clk_sys);
      chk("resume", 1, resume);
      @(negedge clk_sys);
      chk("halted", 0, {resume, halted});
   endtask
   task automatic t_emu_dma();
      {ctc, slow} = {2'h0, 1'b1};
      repeat (20) @(negedge clk_sys);
      {idle_exec, cmd} = {1'b1, 32'h0001_0000};
      repeat (60) @(negedge clk_sys);
      chk("state", DSW_ARMED, state);
      chk("standby", 0, {standby, emu_clk_core});
      dbg = 1'b1;
      wait_st(DSW_SLEEP);
      chk("state", DSW_SLEEP, state);
      dma_irq = '{region: 8'h80, global_irq: 1'b1};
      @(negedge clk_sys);
      chk("dma_irq_out", 9'h101, dma_out);
      chk("internal_dma_evt", 9'h101, int_evt);
      evt_in[24:16] = int_evt;
      repeat (10) @(negedge clk_sys);
      chk("state", DSW_SLEEP, state);
      evt_in[32] = dma_out.region[7];
      wait_st(DSW_WAKE);
      chk("state", DSW_WAKE, state);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial
   begin
      emu_clk_src = 1'b0;
      forever @(negedge clk_sys) emu_clk_src = ~emu_clk_src;
   end
   initial
   begin
      {rst_n, idle_exec, dbg, slow, cmd, ctc, evt_in, dma_irq} = '0;
      repeat (6) @(negedge clk_sys);
      rst_n = 1'b1;
      t_no_idle();
      t_sleep_wake();
      t_emu_dma();
      close_out();
   end
   initial
   begin
      #20us;
      fail_count++;
      close_out();
   end
endmodule // tb_dsw_sleep_wake_control
